// File: logic/can_accept_filter.sv
// Acceptance filter configuration and match engine with Wishbone registers.
// Assumes the protocol engine and the bus master share clk_i.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module can_accept_filter
   import can_filt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Received frames from the protocol engine
   input wire logic frame_valid_i,
   input wire logic [ID_W-1:0] frame_eid_i,
   input wire logic [FIDX_W-1:0] frame_buf_i,
   input wire logic [NUM_FILTERS-1:0] buf_full_i,
   output logic frame_ready_o,
   // Match result
   output logic hit_valid_o,
   output logic hit_o,
   output logic [FIDX_W-1:0] hit_filter_o,
   output logic irq_o
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SCAN = 3'b010,
      ST_DONE = 3'b100
   } scan_state_e;

   scan_state_e state_reg, state_next;
   logic [4:0] cnt_reg;
   logic [ID_W-1:0] eid_reg;
   logic [FIDX_W-1:0] buf_reg;
   logic found_reg;
   logic [FIDX_W-1:0] found_idx_reg;
   logic ready_reg;
   logic hit_valid_reg, hit_reg;
   logic [FIDX_W-1:0] hit_filter_reg;

   logic pend_reg, ack_reg;
   logic [31:0] dat_reg;
   logic [15:0] msel_reg;
   logic [ID_W-1:0] mask0_reg, mask1_reg, mask2_reg;
   logic [15:0] ovf_reg, ovf_next;
   logic [15:0] fen_reg;
   logic [2:0] istat_reg, istat_next;
   logic [2:0] imask_reg;
   logic irq_reg;

   // Port bundle to the identifier store
   filt_mem_if mem ();

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire frame_take = frame_valid_i && ready_reg;
   wire scan_busy = (state_reg != ST_IDLE);
   // Frames win a tie so the store is never shared mid-scan
   wire bus_start = wb_cyc_i && wb_stb_i && !pend_reg && !ack_reg && !scan_busy
                    && !frame_take;
   // Access in flight, one cycle after it was taken
   wire bus_wr = pend_reg && wb_we_i;
   wire bus_rd = pend_reg && !wb_we_i;
   wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [15:0] wr_lo = wb_dat_i[15:0];
   // Register select from the byte address
   wire hit_filt = (wb_adr_i <= FILT_LAST_OFF);
   wire hit_msel = (wb_adr_i == MSEL_OFF);
   wire hit_m0 = (wb_adr_i == MASK0_OFF);
   wire hit_m1 = (wb_adr_i == MASK1_OFF);
   wire hit_m2 = (wb_adr_i == MASK2_OFF);
   wire hit_ovf = (wb_adr_i == OVF_OFF);
   wire hit_fen = (wb_adr_i == FEN_OFF);
   wire hit_ist = (wb_adr_i == ISTAT_OFF);
   wire hit_imk = (wb_adr_i == IMASK_OFF);
   wire hit_res = (wb_adr_i == RESULT_OFF);

   // Store port: scan owns the read address while busy
   assign mem.we = bus_wr && hit_filt;
   assign mem.wbe = wb_sel_i[1:0];
   assign mem.waddr = wb_adr_i[5:2];
   assign mem.wdata = wr_lo;
   assign mem.raddr = scan_busy ? cnt_reg[3:0] : wb_adr_i[5:2];

   filt_id_store u_store (
      .clk_i (clk_i),
      .mem (mem)
   );

   // ----------------------------------------------------------------
   // Match engine
   // ----------------------------------------------------------------
   // Filter under test is the one addressed in the previous cycle
   wire [FIDX_W-1:0] cmp_idx = 4'(cnt_reg - 5'h01);
   wire cmp_valid = (state_reg == ST_SCAN) && (cnt_reg != 5'h00);
   wire [SEL_W-1:0] cmp_src = (cmp_idx < 4'(NUM_SEL_FILTERS)) ?
                              msel_reg[{cmp_idx[2:0], 1'b0} +: SEL_W] : MSRC_SET0;
   wire cmp_match;
   wire ovf_event = (state_reg == ST_DONE) && found_reg && buf_full_i[buf_reg];

   filt_match u_match (
      .eid_i (eid_reg),
      .filt_i (mem.rdata),
      .mask0_i (mask0_reg),
      .mask1_i (mask1_reg),
      .mask2_i (mask2_reg),
      .src_i (cmp_src),
      .enable_i (fen_reg[cmp_idx]),
      .match_o (cmp_match)
   );

   // Next scan state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (frame_take) begin
               state_next = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (cnt_reg == SCAN_END) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Scan sequencing and frame capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 5'h00;
         eid_reg <= '0;
         buf_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (state_reg == ST_SCAN) ? cnt_reg + 5'h01 : 5'h00;
         if (frame_take) begin
            eid_reg <= frame_eid_i;
            buf_reg <= frame_buf_i;
         end
      end
   end

   // Lowest-numbered matching filter wins
   always_ff @(posedge clk_i) begin
      if (rst_i || frame_take) begin
         found_reg <= 1'b0;
         found_idx_reg <= '0;
      end else if (cmp_valid && cmp_match && !found_reg) begin
         found_reg <= 1'b1;
         found_idx_reg <= cmp_idx;
      end
   end

   // Result outputs and frame handshake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_reg <= 1'b0;
         hit_valid_reg <= 1'b0;
         hit_reg <= 1'b0;
         hit_filter_reg <= '0;
      end else begin
         ready_reg <= (state_next == ST_IDLE) && !bus_start;
         hit_valid_reg <= (state_reg == ST_DONE);
         if (state_reg == ST_DONE) begin
            hit_reg <= found_reg;
            hit_filter_reg <= found_idx_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle
   always_comb begin
      ovf_next = ovf_reg;
      if (bus_wr && hit_ovf) begin
         ovf_next = ovf_reg & ~(~wr_lo & lane_mask);
      end
      if (ovf_event) begin
         ovf_next[buf_reg] = 1'b1;
      end
   end

   // Sticky events, cleared by reading the status word
   always_comb begin
      istat_next = istat_reg;
      if (bus_rd && hit_ist) begin
         istat_next = 3'h0;
      end
      if (state_reg == ST_DONE) begin
         istat_next[IRQ_HIT_BIT] = istat_next[IRQ_HIT_BIT] | found_reg;
         istat_next[IRQ_MISS_BIT] = istat_next[IRQ_MISS_BIT] | !found_reg;
      end
      if (ovf_event) begin
         istat_next[IRQ_OVF_BIT] = 1'b1;
      end
   end

   // Configuration writes honour byte lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msel_reg <= MSEL_RST;
         mask0_reg <= MASK_RST;
         mask1_reg <= MASK_RST;
         mask2_reg <= MASK_RST;
         fen_reg <= FEN_RST;
         imask_reg <= IRQ_RST;
      end else if (bus_wr) begin
         if (hit_msel) msel_reg <= (msel_reg & ~lane_mask) | (wr_lo & lane_mask);
         if (hit_m0) mask0_reg <= (mask0_reg & ~lane_mask) | (wr_lo & lane_mask);
         if (hit_m1) mask1_reg <= (mask1_reg & ~lane_mask) | (wr_lo & lane_mask);
         if (hit_m2) mask2_reg <= (mask2_reg & ~lane_mask) | (wr_lo & lane_mask);
         if (hit_fen) fen_reg <= (fen_reg & ~lane_mask) | (wr_lo & lane_mask);
         if (hit_imk && wb_sel_i[0]) imask_reg <= wb_dat_i[2:0];
      end
   end

   // Status, flags and interrupt line
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_reg <= OVF_RST;
         istat_reg <= IRQ_RST;
         irq_reg <= 1'b0;
      end else begin
         ovf_reg <= ovf_next;
         istat_reg <= istat_next;
         irq_reg <= |(istat_next & imask_reg);
      end
   end

   // ----------------------------------------------------------------
   // Bus answer: request taken, then ack with data two edges later
   // ----------------------------------------------------------------
   // Read selection for the addressed register
   wire [31:0] rd_mux =
      hit_filt ? {16'h0000, mem.rdata} :
      hit_msel ? {16'h0000, msel_reg} :
      hit_m0 ? {16'h0000, mask0_reg} :
      hit_m1 ? {16'h0000, mask1_reg} :
      hit_m2 ? {16'h0000, mask2_reg} :
      hit_ovf ? {16'h0000, ovf_reg} :
      hit_fen ? {16'h0000, fen_reg} :
      hit_ist ? {29'h00000000, istat_reg} :
      hit_imk ? {29'h00000000, imask_reg} :
      hit_res ? {26'h0000000, scan_busy, hit_reg, hit_filter_reg} :
      32'h00000000; // Unmapped reads as zero

   // Ack and read data two cycles after the request is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= 1'b0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         pend_reg <= bus_start;
         ack_reg <= pend_reg;
         dat_reg <= bus_rd ? rd_mux : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Registered values straight to the ports
   assign wb_dat_o = dat_reg;
   assign wb_ack_o = ack_reg;
   assign frame_ready_o = ready_reg;
   assign hit_valid_o = hit_valid_reg;
   assign hit_o = hit_reg;
   assign hit_filter_o = hit_filter_reg;
   assign irq_o = irq_reg;
endmodule : can_accept_filter
`default_nettype wire

// File: logic/can_filt_pkg.sv
// Constants shared by the acceptance filter block and its helpers.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
package can_filt_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NUM_FILTERS = 16;
   localparam int NUM_SEL_FILTERS = 8;
   localparam int ID_W = 16;
   localparam int FIDX_W = 4;
   localparam int SEL_W = 2;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] FILT_BASE_OFF = 8'h00; // 16 words, one per filter
   localparam logic [7:0] FILT_LAST_OFF = 8'h3c;
   localparam logic [7:0] MSEL_OFF = 8'h40;
   localparam logic [7:0] MASK0_OFF = 8'h44;
   localparam logic [7:0] MASK1_OFF = 8'h48;
   localparam logic [7:0] MASK2_OFF = 8'h4c;
   localparam logic [7:0] OVF_OFF = 8'h50;
   localparam logic [7:0] FEN_OFF = 8'h54;
   localparam logic [7:0] ISTAT_OFF = 8'h58;
   localparam logic [7:0] IMASK_OFF = 8'h5c;
   localparam logic [7:0] RESULT_OFF = 8'h60;
   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [15:0] MSEL_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] OVF_RST = 16'h0000;
   localparam logic [15:0] FEN_RST = 16'h0000;
   localparam logic [2:0] IRQ_RST = 3'h0;
   localparam logic [1:0] MSRC_SET0 = 2'h0;
   localparam logic [1:0] MSRC_SET1 = 2'h1;
   localparam logic [1:0] MSRC_SET2 = 2'h2;
   localparam logic [1:0] MSRC_RSVD = 2'h3;
   // Interrupt status bit positions
   localparam int IRQ_HIT_BIT = 0;
   localparam int IRQ_MISS_BIT = 1;
   localparam int IRQ_OVF_BIT = 2;
   // Scan counter end value: one pipeline slot per filter plus one
   localparam logic [4:0] SCAN_END = 5'h10;
endpackage : can_filt_pkg

// File: logic/filt_mem_if.sv
// Port bundle between the controller and the filter identifier store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface filt_mem_if;
   logic we;
   logic [1:0] wbe;
   logic [3:0] waddr;
   logic [15:0] wdata;
   logic [3:0] raddr;
   logic [15:0] rdata;
   modport ctrl (output we, output wbe, output waddr, output wdata, output raddr,
                 input rdata);
   modport store (input we, input wbe, input waddr, input wdata, input raddr,
                  output rdata);
endinterface : filt_mem_if
`default_nettype wire

// File: logic/filt_id_store.sv
// Sixteen-word store of filter identifier match bits.
// Assumes one write and one registered read port on clk_i.
`timescale 1ns/100ps
`default_nettype none
module filt_id_store
   import can_filt_pkg::*;
(
   input wire logic clk_i,
   filt_mem_if.store mem
);
   logic [ID_W-1:0] rdata;

   // One memory per byte lane, so each lane has a single writer
   for (genvar b = 0; b < 2; b++) begin : g_lane
      logic [7:0] words [NUM_FILTERS];
      logic [7:0] rd_reg;
      // Lane write and registered read, contents undefined until written
      always_ff @(posedge clk_i) begin
         if (mem.we && mem.wbe[b]) begin
            words[mem.waddr] <= mem.wdata[b*8 +: 8];
         end
         rd_reg <= words[mem.raddr];
      end
      assign rdata[b*8 +: 8] = rd_reg;
   end
   assign mem.rdata = rdata;
endmodule : filt_id_store
`default_nettype wire

// File: logic/filt_match.sv
// Compares one received extended identifier against one filter.
// Assumes the caller supplies the three mask sets and the filter's source code.
`timescale 1ns/100ps
`default_nettype none
module filt_match
   import can_filt_pkg::*;
(
   input wire logic [ID_W-1:0] eid_i,
   input wire logic [ID_W-1:0] filt_i,
   input wire logic [ID_W-1:0] mask0_i,
   input wire logic [ID_W-1:0] mask1_i,
   input wire logic [ID_W-1:0] mask2_i,
   input wire logic [SEL_W-1:0] src_i,
   input wire logic enable_i,
   output logic match_o
);
   logic [ID_W-1:0] mask;
   logic src_ok;
   logic [ID_W-1:0] diff;

   // Mask set selection, reserved code disables the filter
   assign mask = (src_i == MSRC_SET2) ? mask2_i :
                 (src_i == MSRC_SET1) ? mask1_i : mask0_i;
   assign src_ok = (src_i != MSRC_RSVD);
   // Set match bit needs a one, cleared bit needs a zero
   assign diff = eid_i ^ filt_i;
   // Only mask-enabled positions take part
   assign match_o = enable_i && src_ok && ((diff & mask) == '0);
endmodule : filt_match
`default_nettype wire

// File: test/can_accept_filter_props.sv
// Concurrent checks on the acceptance filter block's top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module can_accept_filter_props
   import can_filt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic frame_valid_i,
   input wire logic frame_ready_o,
   input wire logic hit_valid_o,
   input wire logic hit_o,
   input wire logic [FIDX_W-1:0] hit_filter_o,
   input wire logic irq_o
);
   // ------------------------------
   // Sequences and properties
   // ------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence take_s;
      frame_valid_i && frame_ready_o;
   endsequence
   sequence req_s;
      wb_cyc_i && wb_stb_i && !$past(wb_stb_i);
   endsequence
   AST_SCAN_LEN: assert property (take_s |-> !hit_valid_o [*8] ##12 hit_valid_o)
      else $error("result pulse not 19 cycles after take");
   AST_READY_LOW: assert property (take_s |=> !frame_ready_o [*8])
      else $error("frame ready during scan");
   AST_ACK_LAT: assert property (req_s |-> !wb_ack_o ##1 !wb_ack_o ##[1:30] wb_ack_o)
      else $error("bus answer too early or missing");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero without ack");
   AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper read data not zero");
   AST_RST_QUIET: assert property ($past(rst_i) |-> !irq_o && !hit_o && !wb_ack_o)
      else $error("outputs active after reset");
   AST_HOLD: assert property (!hit_valid_o |-> $stable(hit_o) && $stable(hit_filter_o))
      else $error("result changed without a result pulse");
endmodule : can_accept_filter_props
bind can_accept_filter can_accept_filter_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .frame_valid_i(frame_valid_i), .frame_ready_o(frame_ready_o), .hit_valid_o(hit_valid_o),
   .hit_o(hit_o), .hit_filter_o(hit_filter_o), .irq_o(irq_o));
`default_nettype wire

// File: test/can_frame_src.sv
// Protocol engine model offering received frames to the filter.
// Assumes the bench pulses start_i once per frame and awaits its result.
`timescale 1ns/100ps
`default_nettype none
module can_frame_src (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [3:0] wait_i,
   input wire logic [15:0] eid_i,
   input wire logic [3:0] buf_i,
   input wire logic frame_ready_i,
   output logic frame_valid_o,
   output logic [15:0] frame_eid_o,
   output logic [3:0] frame_buf_o
);
   logic pend_reg;
   logic [3:0] cnt_reg;
   logic [15:0] eid_reg;
   logic [3:0] buf_reg;
   // ------------------------------
   // Offer, stale lines inverted
   // ------------------------------
   assign frame_valid_o = pend_reg && (cnt_reg == 4'h0);
   assign frame_eid_o = frame_valid_o ? eid_reg : ~eid_reg;
   assign frame_buf_o = frame_valid_o ? buf_reg : ~buf_reg;
   // Wait a while, then hold until taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (start_i) begin
         pend_reg <= 1'b1;
         cnt_reg <= wait_i;
         eid_reg <= eid_i;
         buf_reg <= buf_i;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end else if (frame_valid_o && frame_ready_i) begin
         pend_reg <= 1'b0;
      end
   end
endmodule : can_frame_src
`default_nettype wire

// File: test/can_accept_filter_tb.sv
// Self-checking bench for the acceptance filter block.
// Assumes the frame source model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module can_accept_filter_tb;
   import can_filt_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, wt = 4'h0, bufn = 4'h0, fbuf, hidx;
   logic [31:0] dat = 32'h00000000, rdat;
   logic [15:0] extended_id_match_bits = 16'h0000, feid, full = 16'h0000, msel, fen, e;
   logic [2:0] ist = 3'h0; // Hit and miss events of every frame sent, never cleared
   logic ack, fval, frdy, hval, hit, irq;
   logic [15:0] filt [16];
   logic [15:0] mk [3];
   int bad_count = 0, checks_done = 0, seed = 20;
   // ------------------------------
   // Clock, design and frame source
   // ------------------------------
   always #4 clk_i = ~clk_i;
   can_accept_filter dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .frame_valid_i(fval), .frame_eid_i(feid), .frame_buf_i(fbuf),
      .buf_full_i(full), .frame_ready_o(frdy), .hit_valid_o(hval), .hit_o(hit),
      .hit_filter_o(hidx), .irq_o(irq));
   can_frame_src src_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .wait_i(wt),
      .eid_i(extended_id_match_bits), .buf_i(bufn), .frame_ready_i(frdy), .frame_valid_o(fval),
      .frame_eid_o(feid), .frame_buf_o(fbuf));
   // Lowest enabled filter whose compared bits agree
   function automatic logic [4:0] expect_hit(input logic [15:0] v);
      logic [15:0] m;
      for (int i = 0; i < 16; i++) begin
         if (i < 8 && msel[2*i+:2] == MSRC_RSVD) continue;
         m = (i < 8) ? mk[msel[2*i+:2]] : mk[0];
         if (fen[i] && ((v ^ filt[i]) & m) == 16'h0) return {1'b1, 4'(i)};
      end
      return 5'h0;
   endfunction : expect_hit
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {16'h0, d};
      sel <= 4'h3;
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 60);
      if (ack !== 1'b1) begin bad_count++; close_out(); end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] x);
      logic [31:0] q;
      wb(1'b0, a, 16'h0, q);
      `CHK(n, {16'h0, x}, q)
   endtask : rdc
   task automatic frame(input logic [15:0] v, input logic [3:0] b);
      logic [4:0] x;
      int n;
      x = expect_hit(v);
      ist = ist | (x[4] ? 3'h1 : 3'h2);
      @(posedge clk_i);
      start <= 1'b1;
      extended_id_match_bits <= v;
      bufn <= b;
      wt <= 4'($random(seed) & 3);
      @(posedge clk_i);
      start <= 1'b0;
      n = 0;
      do begin @(posedge clk_i); n++; end while (hval !== 1'b1 && n < 80);
      if (hval !== 1'b1) begin bad_count++; close_out(); end
      `CHK("hit", x[4], hit)
      if (x[4]) `CHK("idx", x[3:0], hidx)
   endtask : frame
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("msel", MSEL_OFF, 16'h0);
      rdc("ovf", OVF_OFF, 16'h0);
      rdc("unmapped", 8'hfc, 16'h0);
      for (int i = 0; i < 16; i++) begin
         filt[i] = 16'($random(seed));
         wr(FILT_BASE_OFF + 8'(4 * i), filt[i]);
      end
      for (int i = 0; i < 16; i++) rdc("filt", 8'(4 * i), filt[i]);
      fen = 16'hffff;
      wr(FEN_OFF, fen);
      mk = '{16'hffff, 16'h00ff, 16'hff00};
      for (int k = 0; k < 3; k++) begin
         wr(MASK0_OFF + 8'(4 * k), mk[k]);
         rdc("mask", MASK0_OFF + 8'(4 * k), mk[k]);
      end
      $display("test registers done");
      for (int t = 0; t < 36; t++) begin
         if (t % 4 == 0) begin
            msel = (t == 0) ? 16'he4e4 : 16'($random(seed));
            wr(MSEL_OFF, msel);
            rdc("msel", MSEL_OFF, msel);
         end
         e = 16'($random(seed)) & (t % 3 == 0 ? 16'h0 : t % 3 == 1 ? 16'hff00 : 16'hffff);
         frame(filt[$random(seed) & 15] ^ e, 4'h0);
      end
      $display("test matching done");
      rdc("istat", ISTAT_OFF, {13'h0000, ist});
      wr(IMASK_OFF, 16'h0004);
      rdc("imask", IMASK_OFF, 16'h0004);
      mk[0] = 16'h0;
      wr(MASK0_OFF, 16'h0);
      msel = 16'h0;
      wr(MSEL_OFF, 16'h0);
      full <= 16'h0200;
      frame(16'h1234, 4'h9);
      @(negedge clk_i) `CHK("irq", 1'b1, irq)
      rdc("result", RESULT_OFF, 16'h0010);
      rdc("ovf", OVF_OFF, 16'h0200);
      wr(OVF_OFF, 16'hffff);
      rdc("ovf", OVF_OFF, 16'h0200);
      wr(OVF_OFF, 16'h0);
      rdc("ovf", OVF_OFF, 16'h0);
      rdc("istat", ISTAT_OFF, 16'h5);
      @(negedge clk_i) `CHK("irq", 1'b0, irq)
      full <= 16'hfdff;
      frame(16'h4321, 4'h9);
      rdc("ovf", OVF_OFF, 16'h0);
      fen = 16'h0;
      wr(FEN_OFF, 16'h0);
      frame(16'h0, 4'h1);
      rdc("result", RESULT_OFF, 16'h0000);
      rdc("istat", ISTAT_OFF, 16'h3);
      rdc("istat", ISTAT_OFF, 16'h0);
      `CHK("irq", 1'b0, irq)
      $display("test overflow done");
      close_out();
   end
endmodule : can_accept_filter_tb
`default_nettype wire
